// *** display_sequencer_htiming.sv ***
// display sequencer, host port decode, plane mapping and horizontal timing
`timescale 1ns/10ps
module display_sequencer_htiming (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // host i/o port bus, same clock domain
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_claim,
    // cpu memory access
    input wire logic mem_req,
    input wire logic [17:0] mem_addr,
    output logic mem_grant,
    output logic [3:0] plane_write_enable,
    output logic [1:0] plane_read_select,
    output logic [15:0] plane_addr,
    // character fetch inputs and font outputs
    input wire logic [7:0] char_code,
    input wire logic attr_bit3,
    output logic ninth_dot_copy,
    output logic [2:0] font_block,
    // vertical timing from the vertical section
    input wire logic vsync_in,
    input wire logic vde_in,
    output logic vsync_out,
    // clocks and horizontal timing
    output logic dot_tick,
    output logic char_tick,
    output logic shift_load,
    output logic h_display_enable,
    output logic h_blank,
    output logic refresh_enable,
    output logic cpu_full_bandwidth,
    output logic [1:0] clock_select
);

    // host visible registers
    logic [7:0] misc_output;
    logic [7:0] feature_control;
    logic [7:0] subsystem_enable;
    logic [7:0] sequencer_index;
    logic [7:0] sequencer_clear_control;
    logic [7:0] clocking_control;
    logic [7:0] plane_write_mask;
    logic [7:0] font_select;
    logic [7:0] memory_addressing_mode;
    logic [7:0] timing_index;
    logic [7:0] horizontal_total;
    logic [7:0] horizontal_display_end;
    logic [7:0] horizontal_blank_start;
    logic [7:0] horizontal_blank_end;
    logic [7:0] horizontal_retrace_end;

    // sequencer and timing state
    logic dot_phase;
    logic [3:0] dot_count;
    logic [1:0] load_count;
    logic halted;
    logic [7:0] h_count;
    logic blank_state;
    logic [2:0] de_pipe;

    // port decode; the subsystem enable port stays reachable so decoding can be turned back on
    wire decode_on = subsystem_enable[0];
    wire [15:0] tg_base = misc_output[display_timing_pkg::MISC_EMUL] ?
        display_timing_pkg::PORT_COLOR_BASE : display_timing_pkg::PORT_MONO_BASE;
    wire in_tg_page = decode_on && io_addr[15:4] == tg_base[15:4];
    wire sel_subsys = io_addr == display_timing_pkg::PORT_SUBSYS;
    wire sel_misc_w = decode_on && io_addr == display_timing_pkg::PORT_MISC_WRITE;
    wire sel_misc_r = decode_on && io_addr == display_timing_pkg::PORT_MISC_READ;
    wire sel_seq_index = decode_on && io_addr == display_timing_pkg::PORT_SEQ_INDEX;
    wire sel_seq_data = decode_on && io_addr == display_timing_pkg::PORT_SEQ_DATA;
    wire sel_feat_r = decode_on && io_addr == display_timing_pkg::PORT_FEATURE_READ;
    wire sel_feat_w = in_tg_page && io_addr[3:0] == display_timing_pkg::PORT_FEATURE_WRITE_LOW;
    wire sel_tg_index = in_tg_page && io_addr[3:0] == display_timing_pkg::PORT_TIMING_INDEX_LOW;
    wire sel_tg_data = in_tg_page && io_addr[3:0] == display_timing_pkg::PORT_TIMING_DATA_LOW;
    wire [2:0] seq_ptr = sequencer_index[2:0];
    wire [4:0] tg_ptr = timing_index[4:0];

    // write strobes per register
    wire wr_seq = io_wr && sel_seq_data;
    wire wr_tg = io_wr && sel_tg_data;
    wire wr_clear = wr_seq && seq_ptr == display_timing_pkg::SEQ_CLEAR;
    wire wr_clocking = wr_seq && seq_ptr == display_timing_pkg::SEQ_CLOCKING;
    wire wr_mask = wr_seq && seq_ptr == display_timing_pkg::SEQ_PLANE_MASK;
    wire wr_font = wr_seq && seq_ptr == display_timing_pkg::SEQ_FONT;
    wire wr_mode = wr_seq && seq_ptr == display_timing_pkg::SEQ_MEM_MODE;
    wire wr_htotal = wr_tg && tg_ptr == display_timing_pkg::TG_HTOTAL;
    wire wr_hde = wr_tg && tg_ptr == display_timing_pkg::TG_HDE_END;
    wire wr_hbs = wr_tg && tg_ptr == display_timing_pkg::TG_HBLANK_START;
    wire wr_hbe = wr_tg && tg_ptr == display_timing_pkg::TG_HBLANK_END;
    wire wr_hre = wr_tg && tg_ptr == display_timing_pkg::TG_HRETRACE_END;

    // read data selection; reserved bits read as zero
    logic [7:0] seq_read;
    logic [7:0] tg_read;
    always_comb begin
        case (seq_ptr)
            display_timing_pkg::SEQ_CLEAR: seq_read = {6'h00, sequencer_clear_control[1:0]};
            display_timing_pkg::SEQ_CLOCKING: seq_read = {2'h0, clocking_control[5:2], 1'b0, clocking_control[0]};
            display_timing_pkg::SEQ_PLANE_MASK: seq_read = {4'h0, plane_write_mask[3:0]};
            display_timing_pkg::SEQ_FONT: seq_read = {2'h0, font_select[5:0]};
            display_timing_pkg::SEQ_MEM_MODE: seq_read = {4'h0, memory_addressing_mode[3:1], 1'b0};
            default: seq_read = 8'h00;
        endcase
    end
    always_comb begin
        case (tg_ptr)
            display_timing_pkg::TG_HTOTAL: tg_read = horizontal_total;
            display_timing_pkg::TG_HDE_END: tg_read = horizontal_display_end;
            display_timing_pkg::TG_HBLANK_START: tg_read = horizontal_blank_start;
            display_timing_pkg::TG_HBLANK_END: tg_read = horizontal_blank_end;
            display_timing_pkg::TG_HRETRACE_END: tg_read = horizontal_retrace_end;
            default: tg_read = 8'h00;
        endcase
    end
    wire claim_now = sel_subsys || sel_misc_w || sel_misc_r || sel_seq_index || sel_seq_data
        || sel_feat_r || sel_feat_w || sel_tg_index || sel_tg_data;
    wire [7:0] next_rdata = sel_subsys ? {7'h00, subsystem_enable[0]} :
        sel_misc_r ? misc_output :
        sel_seq_index ? {5'h00, seq_ptr} :
        sel_seq_data ? seq_read :
        sel_feat_r ? {4'h0, feature_control[3], 3'h0} :
        sel_tg_index ? {2'h0, timing_index[5:0]} :
        sel_tg_data ? tg_read : 8'h00;

    // read answer one cycle after the strobe; unclaimed reads answer zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
            io_claim <= 1'b0;
        end else begin
            io_rdata <= io_rd ? next_rdata : 8'h00;
            io_claim <= (io_rd || io_wr) && claim_now;
        end
    end

    // general and index registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            misc_output <= display_timing_pkg::RST_ZERO;
            feature_control <= display_timing_pkg::RST_ZERO;
            subsystem_enable <= display_timing_pkg::RST_SUBSYS;
            sequencer_index <= display_timing_pkg::RST_ZERO;
            timing_index <= display_timing_pkg::RST_ZERO;
        end else begin
            if (io_wr && sel_misc_w) misc_output <= io_wdata;
            if (io_wr && sel_feat_w) feature_control <= io_wdata;
            if (io_wr && sel_subsys) subsystem_enable <= io_wdata;
            if (io_wr && sel_seq_index) sequencer_index <= io_wdata;
            if (io_wr && sel_tg_index) timing_index <= io_wdata;
        end
    end

    // sequencer data registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sequencer_clear_control <= display_timing_pkg::RST_CLEAR;
            clocking_control <= display_timing_pkg::RST_ZERO;
            plane_write_mask <= display_timing_pkg::RST_PLANE_MASK;
            font_select <= display_timing_pkg::RST_ZERO;
            memory_addressing_mode <= display_timing_pkg::RST_ZERO;
        end else begin
            if (wr_clear) sequencer_clear_control <= io_wdata;
            if (wr_clocking) clocking_control <= io_wdata;
            if (wr_mask) plane_write_mask <= io_wdata;
            if (wr_font) font_select <= io_wdata;
            if (wr_mode) memory_addressing_mode <= io_wdata;
        end
    end

    // horizontal timing registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            horizontal_total <= display_timing_pkg::RST_ZERO;
            horizontal_display_end <= display_timing_pkg::RST_ZERO;
            horizontal_blank_start <= display_timing_pkg::RST_ZERO;
            horizontal_blank_end <= display_timing_pkg::RST_ZERO;
            horizontal_retrace_end <= display_timing_pkg::RST_ZERO;
        end else begin
            if (wr_htotal) horizontal_total <= io_wdata;
            if (wr_hde) horizontal_display_end <= io_wdata;
            if (wr_hbs) horizontal_blank_start <= io_wdata;
            if (wr_hbe) horizontal_blank_end <= io_wdata;
            if (wr_hre) horizontal_retrace_end <= io_wdata;
        end
    end

    // sequencer clocking: the fast clear acts on the next edge, the slow one waits for a character edge
    wire async_clear = !sequencer_clear_control[0];
    wire sync_clear = !sequencer_clear_control[1];
    wire div2 = clocking_control[display_timing_pkg::CLK_DOT_DIV2];
    wire eight_dot = clocking_control[display_timing_pkg::CLK_EIGHT_DOT];
    wire screen_off = clocking_control[display_timing_pkg::CLK_SCREEN_OFF];
    wire running = !halted && !async_clear;
    wire dot_step = running && (!div2 || dot_phase);
    wire [3:0] dot_last = eight_dot ? display_timing_pkg::DOTS_EIGHT_LAST :
        display_timing_pkg::DOTS_NINE_LAST;
    wire char_step = dot_step && dot_count == dot_last;
    wire next_halted = async_clear || (sync_clear && (halted || char_step));
    wire load_now = clocking_control[display_timing_pkg::CLK_LOAD4] ? load_count == 2'h0 :
        clocking_control[display_timing_pkg::CLK_LOAD2] ? !load_count[0] : 1'b1;

    // dot and character counters, cleared while halted
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dot_phase <= 1'b0;
            dot_count <= 4'h0;
            load_count <= 2'h0;
            halted <= 1'b0;
        end else begin
            halted <= next_halted;
            if (!running) begin
                dot_phase <= 1'b0;
                dot_count <= 4'h0;
                load_count <= 2'h0;
            end else begin
                dot_phase <= !dot_phase;
                if (char_step) dot_count <= 4'h0;
                else if (dot_step) dot_count <= dot_count + 4'h1;
                if (char_step) load_count <= load_count + 2'h1;
            end
        end
    end

    // horizontal character counter, line period of total plus five characters
    wire line_end = {1'b0, h_count} == {1'b0, horizontal_total} + display_timing_pkg::HTOTAL_ADJUST;
    wire [5:0] blank_end_value = {horizontal_retrace_end[display_timing_pkg::HRE_BLANK_BIT5],
        horizontal_blank_end[4:0]};
    wire de_raw = h_count <= horizontal_display_end;
    wire [1:0] de_skew = horizontal_blank_end[6:5];
    wire de_skewed = de_skew == 2'h0 ? de_raw : de_pipe[de_skew - 2'h1];
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            h_count <= 8'h00;
            blank_state <= 1'b0;
            de_pipe <= 3'h0;
        end else if (!running) begin
            h_count <= 8'h00;
            blank_state <= 1'b0;
            de_pipe <= 3'h0;
        end else if (char_step) begin
            h_count <= line_end ? 8'h00 : h_count + 8'h01;
            if (h_count == horizontal_blank_start) blank_state <= 1'b1;
            else if (h_count[5:0] == blank_end_value) blank_state <= 1'b0;
            de_pipe <= {de_pipe[1:0], de_raw};
        end
    end

    // clock and timing outputs; screen off blanks but sync generation keeps counting
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dot_tick <= 1'b0;
            char_tick <= 1'b0;
            shift_load <= 1'b0;
            h_display_enable <= 1'b0;
            h_blank <= 1'b0;
            refresh_enable <= 1'b0;
            cpu_full_bandwidth <= 1'b0;
            clock_select <= 2'h0;
            vsync_out <= 1'b0;
        end else begin
            dot_tick <= dot_step;
            char_tick <= char_step;
            shift_load <= char_step && load_now;
            h_display_enable <= de_skewed && !screen_off;
            h_blank <= blank_state || screen_off;
            refresh_enable <= !async_clear;
            cpu_full_bandwidth <= screen_off;
            clock_select <= misc_output[3:2];
            vsync_out <= feature_control[display_timing_pkg::FEAT_VSYNC_OR] ?
                (vsync_in || vde_in) : vsync_in;
        end
    end

    // font and ninth dot; without extended memory only font 0 is used
    wire [2:0] font_num = attr_bit3 ? {font_select[5], font_select[3:2]} :
        {font_select[4], font_select[1:0]};
    wire [2:0] font_eff = memory_addressing_mode[display_timing_pkg::MM_EXTENDED] ? font_num : 3'h0;
    wire line_code = char_code >= display_timing_pkg::LINE_CODE_FIRST
        && char_code <= display_timing_pkg::LINE_CODE_LAST;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            font_block <= 3'h0;
            ninth_dot_copy <= 1'b0;
        end else begin
            font_block <= {font_eff[1:0], font_eff[2]};
            ninth_dot_copy <= !eight_dot && line_code;
        end
    end

    // cpu plane mapping: chain mode by A1,A0, sequential when selected, else odd/even by A0, under the mask
    wire chain4 = memory_addressing_mode[display_timing_pkg::MM_CHAIN4];
    wire seq_mode = memory_addressing_mode[display_timing_pkg::MM_SEQUENTIAL];
    wire [3:0] chain_planes = 4'h1 << mem_addr[1:0];
    wire [3:0] odd_even_planes = mem_addr[0] ? 4'hA : 4'h5;
    wire [3:0] mode_planes = chain4 ? chain_planes : (seq_mode ? 4'hF : odd_even_planes);
    wire [3:0] next_we = mode_planes & plane_write_mask[3:0];
    wire [1:0] next_read_sel = chain4 ? mem_addr[1:0] : (seq_mode ? 2'h0 : {1'b0, mem_addr[0]});
    wire [15:0] raw_plane_addr = chain4 ? mem_addr[17:2] : (seq_mode ? mem_addr[15:0] : mem_addr[16:1]);
    wire [15:0] next_plane_addr = memory_addressing_mode[display_timing_pkg::MM_EXTENDED] ? raw_plane_addr :
        (raw_plane_addr & display_timing_pkg::SMALL_MEM_MASK);
    wire mem_ok = mem_req && decode_on;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_grant <= 1'b0;
            plane_write_enable <= 4'h0;
            plane_read_select <= 2'h0;
            plane_addr <= 16'h0000;
        end else begin
            mem_grant <= mem_ok;
            plane_write_enable <= mem_ok ? next_we : 4'h0;
            plane_read_select <= next_read_sel;
            plane_addr <= next_plane_addr;
        end
    end

    property p_vsync_combine;
        @(posedge sys_clk) disable iff (rst)
        feature_control[3] && vde_in |=> vsync_out;
    endproperty
    a_vsync_combine: assert property (p_vsync_combine) else $error("vsync not combined with display enable");

    property p_decode_gated;
        @(posedge sys_clk) disable iff (rst)
        !subsystem_enable[0] && io_rd && io_addr != display_timing_pkg::PORT_SUBSYS |=> !io_claim && io_rdata == 8'h00;
    endproperty
    a_decode_gated: assert property (p_decode_gated) else $error("port answered while decoding off");

    property p_async_halt;
        @(posedge sys_clk) disable iff (rst)
        !sequencer_clear_control[0] |=> !char_tick && !dot_tick && !refresh_enable;
    endproperty
    a_async_halt: assert property (p_async_halt) else $error("sequencer ran during fast clear");

    property p_eight_dot_char;
        @(posedge sys_clk) disable iff (rst)
        char_step && eight_dot && !div2 && sequencer_clear_control[1:0] == 2'h3 && !wr_clear && !wr_clocking
        |=> char_tick ##1 (!char_tick)[*7] ##1 char_tick;
    endproperty
    a_eight_dot_char: assert property (p_eight_dot_char) else $error("eight dot character period wrong");

    property p_line_wrap;
        @(posedge sys_clk) disable iff (rst)
        char_step && line_end |=> h_count == 8'h00;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("character counter did not wrap at total");

    property p_blank_start;
        @(posedge sys_clk) disable iff (rst)
        char_step && h_count == horizontal_blank_start |=> ##1 h_blank;
    endproperty
    a_blank_start: assert property (p_blank_start) else $error("blanking did not start");

    property p_screen_off;
        @(posedge sys_clk) disable iff (rst)
        clocking_control[5] |=> h_blank && !h_display_enable && cpu_full_bandwidth;
    endproperty
    a_screen_off: assert property (p_screen_off) else $error("screen off not honoured");

    property p_chain_plane;
        @(posedge sys_clk) disable iff (rst)
        mem_req && subsystem_enable[0] && memory_addressing_mode[3] && plane_write_mask[3:0] == 4'hF
        && mem_addr[1:0] == 2'h2 |=> plane_write_enable == 4'h4 && plane_read_select == 2'h2;
    endproperty
    a_chain_plane: assert property (p_chain_plane) else $error("chain plane selection wrong");

    property p_font_map;
        @(posedge sys_clk) disable iff (rst)
        attr_bit3 && memory_addressing_mode[1] && font_select[5] && font_select[3:2] == 2'h0 |=> font_block == 3'h1;
    endproperty
    a_font_map: assert property (p_font_map) else $error("font block mapping wrong");

    property p_ninth_dot;
        @(posedge sys_clk) disable iff (rst)
        !clocking_control[0] && char_code == 8'hC5 |=> ninth_dot_copy;
    endproperty
    a_ninth_dot: assert property (p_ninth_dot) else $error("ninth dot not copied");

endmodule : display_sequencer_htiming

// *** display_timing_pkg.sv ***
// constants for the display sequencer and horizontal timing generator
package display_timing_pkg;
    // i/o port addresses
    localparam logic [15:0] PORT_MISC_WRITE = 16'h03C2;
    localparam logic [15:0] PORT_MISC_READ = 16'h03CC;
    localparam logic [15:0] PORT_SUBSYS = 16'h03C3;
    localparam logic [15:0] PORT_SEQ_INDEX = 16'h03C4;
    localparam logic [15:0] PORT_SEQ_DATA = 16'h03C5;
    localparam logic [15:0] PORT_FEATURE_READ = 16'h03CA;
    localparam logic [15:0] PORT_MONO_BASE = 16'h03B0;
    localparam logic [15:0] PORT_COLOR_BASE = 16'h03D0;
    localparam logic [3:0] PORT_TIMING_INDEX_LOW = 4'h4;
    localparam logic [3:0] PORT_TIMING_DATA_LOW = 4'h5;
    localparam logic [3:0] PORT_FEATURE_WRITE_LOW = 4'hA;
    // sequencer indices
    localparam logic [2:0] SEQ_CLEAR = 3'h0;
    localparam logic [2:0] SEQ_CLOCKING = 3'h1;
    localparam logic [2:0] SEQ_PLANE_MASK = 3'h2;
    localparam logic [2:0] SEQ_FONT = 3'h3;
    localparam logic [2:0] SEQ_MEM_MODE = 3'h4;
    // timing generator indices
    localparam logic [4:0] TG_HTOTAL = 5'h00;
    localparam logic [4:0] TG_HDE_END = 5'h01;
    localparam logic [4:0] TG_HBLANK_START = 5'h02;
    localparam logic [4:0] TG_HBLANK_END = 5'h03;
    localparam logic [4:0] TG_HRETRACE_END = 5'h05;
    // field positions
    localparam int FEAT_VSYNC_OR = 3;
    localparam int MISC_EMUL = 0;
    localparam int CLK_SCREEN_OFF = 5;
    localparam int CLK_LOAD4 = 4;
    localparam int CLK_DOT_DIV2 = 3;
    localparam int CLK_LOAD2 = 2;
    localparam int CLK_EIGHT_DOT = 0;
    localparam int MM_CHAIN4 = 3;
    localparam int MM_SEQUENTIAL = 2;
    localparam int MM_EXTENDED = 1;
    localparam int HRE_BLANK_BIT5 = 7;
    // reset values
    localparam logic [7:0] RST_SUBSYS = 8'h01;
    localparam logic [7:0] RST_CLEAR = 8'h03;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PLANE_MASK = 8'h0F;
    // character geometry and masks
    localparam logic [3:0] DOTS_EIGHT_LAST = 4'h7;
    localparam logic [3:0] DOTS_NINE_LAST = 4'h8;
    localparam logic [7:0] LINE_CODE_FIRST = 8'hC0;
    localparam logic [7:0] LINE_CODE_LAST = 8'hDF;
    localparam logic [8:0] HTOTAL_ADJUST = 9'h004;
    localparam logic [15:0] SMALL_MEM_MASK = 16'h3FFF;
endpackage : display_timing_pkg

// *** host_io_model.sv ***
// host processor model: drives the block's i/o port bus
`timescale 1ns/10ps
module host_io_model (
    // bus clock
    input wire logic sys_clk,
    // i/o port bus
    output logic [15:0] io_addr = 16'h0000,
    output logic io_wr = 1'b0,
    output logic io_rd = 1'b0,
    output logic [7:0] io_wdata = 8'h00,
    input wire logic [7:0] io_rdata
);
    // one strobe cycle, held until the taking edge; answer taken just after that same edge
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = wr;
        io_rd = !wr;
        @(posedge sys_clk);
        #1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = ~d; // released data must not look still valid
        q = io_rdata;
    endtask : acc
    // index first, then data; index test bit kept 0 by the 5-bit range
    task automatic put(input logic [15:0] ip, input logic [4:0] idx, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, ip, {3'h0, idx}, q);
        acc(1'b1, ip + 16'h0001, d, q);
    endtask : put
endmodule : host_io_model

// *** display_sequencer_htiming_bench.sv ***
// self-checking bench for the display sequencer and horizontal timing block
`timescale 1ns/10ps
module display_sequencer_htiming_bench;
    logic sys_clk = 1'b0, rst = 1'b1, mem_req = 1'b0, attr_bit3 = 1'b0, vsync_in = 1'b0, vde_in = 1'b0;
    logic [17:0] mem_addr = 18'h00000;
    logic [7:0] char_code = 8'h00, io_rdata, q;
    logic [15:0] io_addr;
    logic io_wr, io_rd, io_claim, mem_grant, vsync_out;
    logic [7:0] io_wdata;
    logic [3:0] we;
    logic ninth, ctick, sload, hde, hblank, refresh, dtick;
    logic [2:0] font;
    logic [1:0] csel;
    logic [15:0] paddr;
    int n_dot = 0, n_char = 0, n_load = 0, n_de = 0, n_blank = 0;
    int n_errors = 0, num_checks = 0;
    typedef struct packed { logic [15:0] ip; logic [4:0] idx; logic [7:0] wd; logic [7:0] rd; } row_t;
    // index port, register, written value, read-back after the read mask
    // first row drops clear bit 1 so the clocking write below is legal
    row_t rows [7] = '{'{16'h03C4, 5'h00, 8'h01, 8'h01},
        '{16'h03C4, 5'h01, 8'hFF, 8'h3D}, '{16'h03C4, 5'h02, 8'hFF, 8'h0F},
        '{16'h03C4, 5'h03, 8'hFF, 8'h3F}, '{16'h03C4, 5'h04, 8'hFF, 8'h0E},
        '{16'h03B4, 5'h00, 8'hFF, 8'hFF}, '{16'h03B4, 5'h01, 8'hA5, 8'hA5}};
    host_io_model host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    display_sequencer_htiming uut (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_claim(io_claim), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_grant(mem_grant), .plane_write_enable(we), .plane_read_select(),
        .plane_addr(paddr), .char_code(char_code), .attr_bit3(attr_bit3), .ninth_dot_copy(ninth),
        .font_block(font), .vsync_in(vsync_in), .vde_in(vde_in), .vsync_out(vsync_out), .dot_tick(dtick),
        .char_tick(ctick), .shift_load(sload), .h_display_enable(hde), .h_blank(hblank),
        .refresh_enable(refresh), .cpu_full_bandwidth(), .clock_select(csel));
    // free-running system clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one memory request; grant and enables land one cycle later
    task automatic mem(input logic [17:0] a, input logic [3:0] e, input logic [7:0] pa);
        @(posedge sys_clk);
        #1;
        mem_req = 1'b1;
        mem_addr = a;
        @(posedge sys_clk);
        #1;
        mem_req = 1'b0;
        chk({3'h0, mem_grant, we}, {3'h0, e != 4'h0, e});
        chk(paddr[7:0], pa);
    endtask : mem
    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    // hang guard, well past the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst = 1'b0;
        foreach (rows[i]) begin
            host.put(rows[i].ip, rows[i].idx, rows[i].wd);
            host.acc(1'b0, rows[i].ip + 16'h0001, 8'h00, q);
            chk(q, rows[i].rd);
        end
        // reset again mid-run: register defaults must return
        rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 rst = 1'b0;
        host.acc(1'b0, 16'h03C3, 8'h00, q);
        chk(q, 8'h01);
        host.acc(1'b1, 16'h03C4, 8'h02, q);
        host.acc(1'b0, 16'h03C5, 8'h00, q);
        chk(q, 8'h0F);
        host.put(16'h03C4, 5'h04, 8'h08);
        mem(18'h00006, 4'h4, 8'h01);
        host.put(16'h03C4, 5'h02, 8'h03);
        host.put(16'h03C4, 5'h04, 8'h00);
        mem(18'h00005, 4'h2, 8'h02);
        host.acc(1'b1, 16'h03C3, 8'h00, q);
        host.acc(1'b0, 16'h03C5, 8'h00, q);
        chk({io_claim, q[6:0]}, 8'h00);
        mem(18'h00001, 4'h0, 8'h00);
        host.acc(1'b1, 16'h03C3, 8'h01, q);
        host.acc(1'b1, 16'h03BA, 8'h08, q);
        vde_in = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h00, vsync_out}, 8'h01);
        // font 4 lives in the second 8K block; line drawing code in nine dot mode
        host.put(16'h03C4, 5'h03, 8'h20);
        host.put(16'h03C4, 5'h04, 8'h02);
        attr_bit3 = 1'b1;
        char_code = 8'hC5;
        repeat (2) @(posedge sys_clk);
        #1 chk({4'h0, ninth, font}, 8'h09);
        // fast clear stops refresh and character clocks
        host.put(16'h03C4, 5'h00, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1 chk({6'h00, refresh, ctick}, 8'h00);
        // clock related changes only while the slow clear holds the sequencer
        host.put(16'h03C4, 5'h00, 8'h01);
        host.put(16'h03C4, 5'h01, 8'h11);
        host.acc(1'b1, 16'h03C2, 8'h0C, q);
        host.put(16'h03B4, 5'h00, 8'h03);
        host.put(16'h03B4, 5'h01, 8'h03);
        host.put(16'h03B4, 5'h02, 8'h05);
        host.put(16'h03B4, 5'h03, 8'h07);
        host.put(16'h03C4, 5'h00, 8'h03);
        // two lines of eight characters of eight dots; window is a whole number of every period
        repeat (16) @(posedge sys_clk);
        repeat (128) begin
            @(posedge sys_clk);
            #1;
            n_dot += dtick;
            n_char += ctick;
            n_load += sload;
            n_de += hde;
            n_blank += hblank;
        end
        chk(n_dot[7:0], 8'h80);
        chk(n_char[7:0], 8'h10);
        chk(n_load[7:0], 8'h04);
        chk(n_de[7:0], 8'h40);
        chk(n_blank[7:0], 8'h20);
        chk({6'h00, csel}, 8'h03);
        end_sim();
    end
endmodule : display_sequencer_htiming_bench
